// ===== hw/pprg_regs.sv
// register bank for pre-driver power save, soft reset and measure select
// assumes an avalon-mm master on ref_clk; bus inputs need no synchroniser
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module pprg_regs
  import pprg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [PPRG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic supply_monitor_save_off,
  output logic hall_input_save_off,
  output logic pump_regulator_save_off,
  output logic charge_pump_save_off,
  output logic global_save_override,
  output logic [PPRG_CHAN_W-1:0] measure_channel_code,
  output logic analog_measure_valid,
  output logic pre_driver_reset
);
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic global_ff;
  logic [7:0] func_ff;
  logic srst_ff;
  logic [PPRG_CHAN_W-1:0] chan_ff;
  logic sup_off_ff;
  logic hall_off_ff;
  logic preg_off_ff;
  logic cp_off_ff;
  logic gov_ff;
  logic valid_ff;
  logic prst_ff;
  logic [PPRG_CHAN_W-1:0] chan_out_ff;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  pprg_settle_if sif ();

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // register index hit; byte address is four times the index
  function automatic logic hit(input logic [PPRG_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[PPRG_ADDR_W-1:PPRG_IDX_SHIFT] ==
      idx[PPRG_ADDR_W-1-PPRG_IDX_SHIFT:0]);
  endfunction

  // legal measurement code; anything else leaves the output invalid
  function automatic logic legal_chan(input logic [PPRG_CHAN_W-1:0] c);
    legal_chan = (c == PPRG_CH_SUPPLY) || (c == PPRG_CH_CURRENT) ||
      (c == PPRG_CH_TEMP) || (c == PPRG_CH_BACK_EMF_DETECT);
  endfunction

  // wait drops for exactly one cycle, then rises to separate requests
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  assign wr_en = avs_write && !wait_ff && avs_byteenable[0];
  assign rd_en = avs_read && wait_ff;
  assign wbyte = avs_writedata[7:0];

  // read data, loaded as wait drops; unmapped reads answer zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= '0;
    end else if (rd_en) begin
      rdata_ff <= '0;
      if (hit(avs_address, PPRG_IDX_GLOBAL)) begin
        rdata_ff[PPRG_BIT_GLOBAL] <= global_ff;
      end
      if (hit(avs_address, PPRG_IDX_FUNC)) begin
        rdata_ff[7:0] <= func_ff;
      end
      if (hit(avs_address, PPRG_IDX_SRST)) begin
        rdata_ff[PPRG_BIT_SRST] <= srst_ff;
      end
      if (hit(avs_address, PPRG_IDX_CHAN)) begin
        rdata_ff[PPRG_CHAN_W-1:0] <= chan_ff;
      end
      if (hit(avs_address, PPRG_IDX_STATUS)) begin
        rdata_ff[3:0] <= {sup_off_ff, hall_off_ff, preg_off_ff, cp_off_ff};
        rdata_ff[PPRG_ST_VALID] <= valid_ff;
        rdata_ff[PPRG_ST_SETTLED] <= sif.settled;
        rdata_ff[PPRG_ST_SRST] <= srst_ff;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // soft reset bit is outside its own reset domain and must be cleared by software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      srst_ff <= PPRG_RST_SRST[PPRG_BIT_SRST];
    end else if (wr_en && hit(avs_address, PPRG_IDX_SRST)) begin
      srst_ff <= wbyte[PPRG_BIT_SRST];
    end
  end

  // global override; held at reset value while soft reset is set
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      global_ff <= PPRG_RST_GLOBAL[PPRG_BIT_GLOBAL];
    end else if (srst_ff) begin
      global_ff <= PPRG_RST_GLOBAL[PPRG_BIT_GLOBAL];
    end else if (wr_en && hit(avs_address, PPRG_IDX_GLOBAL)) begin
      global_ff <= wbyte[PPRG_BIT_GLOBAL];
    end
  end

  // per-function save-off bits, only the four modelled fields store
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      func_ff <= PPRG_RST_FUNC;
    end else if (srst_ff) begin
      func_ff <= PPRG_RST_FUNC;
    end else if (wr_en && hit(avs_address, PPRG_IDX_FUNC)) begin
      func_ff <= wbyte & PPRG_FUNC_MASK;
    end
  end

  // channel code; prohibited codes are stored and routed like legal ones
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_ff <= PPRG_RST_CHAN[PPRG_CHAN_W-1:0];
    end else if (srst_ff) begin
      chan_ff <= PPRG_RST_CHAN[PPRG_CHAN_W-1:0];
    end else if (wr_en && hit(avs_address, PPRG_IDX_CHAN)) begin
      chan_ff <= wbyte[PPRG_CHAN_W-1:0];
    end
  end

  // ****************************************************************
  // outputs to the analog side
  // ****************************************************************
  // override 0 forces every block into power save
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_off_ff <= 1'b0;
      hall_off_ff <= 1'b0;
      preg_off_ff <= 1'b0;
      cp_off_ff <= 1'b0;
    end else begin
      sup_off_ff <= global_ff && func_ff[PPRG_BIT_SUPPLY];
      hall_off_ff <= global_ff && func_ff[PPRG_BIT_HALL];
      preg_off_ff <= global_ff && func_ff[PPRG_BIT_PREG];
      cp_off_ff <= global_ff && func_ff[PPRG_BIT_CP];
    end
  end

  // override copy, same latency as the save-off bits so they never disagree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gov_ff <= 1'b0;
    end else begin
      gov_ff <= global_ff;
    end
  end

  // routed code; prohibited codes still reach the pin but are flagged invalid
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_out_ff <= PPRG_RST_CHAN[PPRG_CHAN_W-1:0];
    end else begin
      chan_out_ff <= chan_ff;
    end
  end

  // validity of the routed level; settle wait is software's job
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= global_ff && legal_chan(chan_ff);
    end
  end

  // pre-driver reset level, one cycle behind the soft reset bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prst_ff <= 1'b0;
    end else begin
      prst_ff <= srst_ff;
    end
  end

  // a new code restarts the settle timer, seen in status
  assign sif.restart = (chan_out_ff != chan_ff);

  pprg_settle_timer u_settle (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sif(sif)
  );

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign supply_monitor_save_off = sup_off_ff;
  assign hall_input_save_off = hall_off_ff;
  assign pump_regulator_save_off = preg_off_ff;
  assign charge_pump_save_off = cp_off_ff;
  assign global_save_override = gov_ff;
  assign measure_channel_code = chan_out_ff;
  assign analog_measure_valid = valid_ff;
  assign pre_driver_reset = prst_ff;
endmodule

// ===== hw/pprg_pkg.sv
// package for the pre-driver power, reset and measurement selector register bank
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package pprg_pkg;
  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] PPRG_IDX_GLOBAL = 8'h02;
  localparam logic [7:0] PPRG_IDX_FUNC = 8'h04;
  localparam logic [7:0] PPRG_IDX_SRST = 8'h06;
  localparam logic [7:0] PPRG_IDX_CHAN = 8'h08;
  localparam logic [7:0] PPRG_IDX_STATUS = 8'h0a;
  localparam int PPRG_ADDR_W = 8;
  localparam int PPRG_IDX_SHIFT = 2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PPRG_BIT_GLOBAL = 0;
  localparam int PPRG_BIT_CP = 0;
  localparam int PPRG_BIT_PREG = 1;
  localparam int PPRG_BIT_HALL = 2;
  localparam int PPRG_BIT_SUPPLY = 3;
  localparam int PPRG_BIT_SRST = 0;
  localparam int PPRG_CHAN_W = 4;
  localparam logic [7:0] PPRG_FUNC_MASK = 8'h0f;
  localparam int PPRG_ST_VALID = 4;
  localparam int PPRG_ST_SETTLED = 5;
  localparam int PPRG_ST_SRST = 6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PPRG_RST_GLOBAL = 8'h00;
  localparam logic [7:0] PPRG_RST_FUNC = 8'h00;
  localparam logic [7:0] PPRG_RST_SRST = 8'h00;
  localparam logic [7:0] PPRG_RST_CHAN = 8'h00;

  // ****************************************************************
  // channel codes
  // ****************************************************************
  localparam logic [3:0] PPRG_CH_SUPPLY = 4'h0;
  localparam logic [3:0] PPRG_CH_CURRENT = 4'h1;
  localparam logic [3:0] PPRG_CH_TEMP = 4'h2;
  localparam logic [3:0] PPRG_CH_BACK_EMF_DETECT = 4'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PPRG_CLK_PERIOD_PS = 5000;
  localparam int PPRG_SETTLE_NS = 1000;
  localparam int PPRG_SETTLE_PS = PPRG_SETTLE_NS * 1000;
  // strictly more than the settle time, so one extra cycle
  localparam int PPRG_SETTLE_CYC =
    (PPRG_SETTLE_PS + PPRG_CLK_PERIOD_PS - 1) / PPRG_CLK_PERIOD_PS + 1;
  localparam int PPRG_CNT_W = 8;

  typedef enum logic [0:0] {
    PPRG_SET_IDLE = 1'b0,
    PPRG_SET_WAIT = 1'b1
  } pprg_settle_state_t;
endpackage

// ===== hw/pprg_settle_if.sv
// carrier between the register bank and its settle timer
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
interface pprg_settle_if;
  logic restart;
  logic settled;
  modport bank (output restart, input settled);
  modport timer (input restart, output settled);
endinterface

// ===== hw/pprg_settle_timer.sv
// settle timer: counts the amplifier settle wait after a channel change
// assumes restart is a one-cycle pulse from logic on ref_clk
`timescale 1ns/1ps
module pprg_settle_timer
  import pprg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  pprg_settle_if.timer sif
);
  pprg_settle_state_t state_ff;
  pprg_settle_state_t nxt_state;
  logic [PPRG_CNT_W-1:0] cnt_ff;
  logic settled_ff;

  // ****************************************************************
  // state
  // ****************************************************************
  // a restart mid-wait starts the wait again from zero
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PPRG_SET_IDLE: nxt_state = sif.restart ? PPRG_SET_WAIT : PPRG_SET_IDLE;
      PPRG_SET_WAIT: begin
        if (!sif.restart && cnt_ff == PPRG_CNT_W'(PPRG_SETTLE_CYC - 1)) begin
          nxt_state = PPRG_SET_IDLE;
        end
      end
      default: nxt_state = PPRG_SET_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= PPRG_SET_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // cycle counter within the wait
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (sif.restart || state_ff == PPRG_SET_IDLE) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // settled flag, high after reset since the mux has been still
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settled_ff <= 1'b1;
    end else begin
      settled_ff <= (nxt_state == PPRG_SET_IDLE);
    end
  end

  assign sif.settled = settled_ff;
endmodule

// ===== testbench/pprg_regs_properties.sv
// checker for the pprg register bank ports
// assumes a bind onto pprg_regs, one clock ref_clk
`timescale 1ns/1ps
module pprg_regs_properties
  import pprg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [PPRG_ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic supply_monitor_save_off,
  input wire logic hall_input_save_off,
  input wire logic pump_regulator_save_off,
  input wire logic charge_pump_save_off,
  input wire logic global_save_override,
  input wire logic [PPRG_CHAN_W-1:0] measure_channel_code,
  input wire logic analog_measure_valid,
  input wire logic pre_driver_reset
);
  // ******
  // accepted writes
  // ******
  logic wr_ok;
  logic func_wr;
  logic chan_wr;
  logic srst_wr;
  logic code_ok;
  logic [3:0] wd;
  logic [3:0] save_v;
  // outputs lag the store edge by one, so checks look two edges on
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign func_wr = wr_ok && avs_address == 8'h10 && global_save_override && !pre_driver_reset;
  assign chan_wr = wr_ok && avs_address == 8'h20 && !pre_driver_reset;
  assign srst_wr = wr_ok && avs_address == 8'h18;
  assign code_ok = measure_channel_code <= PPRG_CH_BACK_EMF_DETECT;
  assign wd = avs_writedata[3:0];
  assign save_v = {supply_monitor_save_off, hall_input_save_off, pump_regulator_save_off,
    charge_pump_save_off};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ******
  // properties
  // ******
  gate_off_a: assert property (!global_save_override |-> save_v == 4'h0)
    else $error("save-off high with override low");
  supply_store_a: assert property (func_wr |-> ##2 save_v[3] == $past(wd[3], 2))
    else $error("supply save-off not stored");
  hall_store_a: assert property (func_wr |-> ##2 save_v[2] == $past(wd[2], 2))
    else $error("hall save-off not stored");
  pump_store_a: assert property (func_wr |-> ##2 save_v[1:0] == $past(wd[1:0], 2))
    else $error("pump save-off not stored");
  chan_store_a: assert property (chan_wr |-> ##2 measure_channel_code == $past(wd, 2))
    else $error("channel code not stored");
  valid_map_a: assert property (analog_measure_valid == (global_save_override && code_ok))
    else $error("measure valid wrong");
  srst_set_a: assert property (srst_wr |-> ##2 pre_driver_reset == $past(wd[0], 2))
    else $error("soft reset bit not stored");
  srst_hold_a: assert property (pre_driver_reset [*2] |-> save_v == 4'h0
    && !analog_measure_valid && measure_channel_code == 4'h0 && !global_save_override)
    else $error("registers not held in soft reset");
  cover property (pre_driver_reset [*2]);
  cover property (analog_measure_valid);
  cover property (global_save_override && !code_ok);
endmodule

bind pprg_regs pprg_regs_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .supply_monitor_save_off(supply_monitor_save_off), .hall_input_save_off(hall_input_save_off),
  .pump_regulator_save_off(pump_regulator_save_off), .charge_pump_save_off(charge_pump_save_off),
  .global_save_override(global_save_override), .measure_channel_code(measure_channel_code),
  .analog_measure_valid(analog_measure_valid), .pre_driver_reset(pre_driver_reset));

// ===== testbench/pprg_mcu_model.sv
// companion controller model: avalon-mm master of the bank
// assumes ref_clk from the bench and one request at a time
`timescale 1ns/1ps
module pprg_mcu_model (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  // ******
  // bus cycles
  // ******
  localparam int SETTLE_CYC = 1000 / 5 + 1;
  // idle levels from time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // request held until waitrequest is sampled low; bounded so a hang shows
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] q, output bit ok);
    ok = 1'b0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk);
      ok = (avs_waitrequest === 1'b0);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // amplifier settle wait before any conversion, strictly over one microsecond
  task automatic wait_settle();
    repeat (SETTLE_CYC) @(posedge ref_clk);
  endtask
endmodule

// ===== testbench/pprg_regs_bench.sv
// self-checking bench for the pprg register bank
// assumes the controller model is the only bus master
`timescale 1ns/1ps
module pprg_regs_bench
  import pprg_pkg::*;
;
  // ******
  // wiring
  // ******
  logic ref_clk;
  logic rst_b;
  logic [7:0] adr;
  logic rd_s, wr_s, wt;
  logic [31:0] wdat, rdat, outs, rd_q;
  logic [3:0] be;
  logic s3, s2, s1, s0, glb, vld, srst;
  logic [3:0] code;
  int n_fail;
  int comparisons;
  bit ok;
  logic [7:0] al[5] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h0c};
  assign outs = {21'h0, srst, vld, code, glb, s3, s2, s1, s0};
  pprg_regs i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .supply_monitor_save_off(s3), .hall_input_save_off(s2),
    .pump_regulator_save_off(s1), .charge_pump_save_off(s0), .global_save_override(glb),
    .measure_channel_code(code), .analog_measure_valid(vld), .pre_driver_reset(srst));
  pprg_mcu_model i_mcu (.ref_clk(ref_clk), .avs_waitrequest(wt), .avs_readdata(rdat),
    .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat),
    .avs_byteenable(be));
  // ******
  // tasks
  // ******
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // two edges after the store the outputs have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e = 4'h1);
    i_mcu.xfer(1'b1, a, d, e, rd_q, ok);
    if (!ok) begin
      n_fail++;
      complete_run();
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    i_mcu.xfer(1'b0, a, 8'h00, 4'h1, rd_q, ok);
    if (!ok) begin
      n_fail++;
      complete_run();
    end
    check(rd_q, exp, what);
  endtask
  // expected outputs: soft reset, valid, code, override, gated save-off bits
  function automatic logic [31:0] eo(logic s, logic g, logic [3:0] c, logic [3:0] f);
    return {21'h0, s, g && c <= PPRG_CH_BACK_EMF_DETECT, c, g, f & {4{g}}};
  endfunction
  // ******
  // clock and sequence
  // ******
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (al[i]) rd(al[i], 32'h0, "reset value");
    rd(8'h28, 32'h20, "reset status");
    check(outs, eo(0, 0, 4'h0, 4'h0), "reset outputs");
    wr(8'h10, 8'hff);
    check(outs, eo(0, 0, 4'h0, 4'h0), "override low");
    rd(8'h10, 32'h0f, "func readback");
    wr(8'h08, 8'h01);
    // one save-off bit at a time so a swapped pair shows
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, 8'h01 << i);
      check(outs, eo(0, 1, 4'h0, 4'h1 << i), "save-off bit");
    end
    wr(8'h10, 8'h0f, 4'h0);
    rd(8'h10, 32'h08, "refused lane");
    // every legal code and one prohibited, upper bits written high
    for (int c = 0; c < 5; c++) begin
      wr(8'h20, 8'hf0 | c[7:0]);
      check(outs, eo(0, 1, c[3:0], 4'h8), "channel route");
      rd(8'h20, c, "channel readback");
    end
    wr(8'h20, 8'h02);
    rd(8'h28, 32'h18, "settle pending");
    i_mcu.wait_settle();
    rd(8'h28, 32'h38, "settle done");
    wr(8'h08, 8'h00);
    check(outs, eo(0, 0, 4'h2, 4'h8), "valid needs override");
    wr(8'h08, 8'h01);
    wr(8'h18, 8'hff);
    check(outs, eo(1, 0, 4'h0, 4'h0), "soft reset outputs");
    rd(8'h18, 32'h01, "soft reset readback");
    rd(8'h10, 32'h0, "func cleared");
    rd(8'h28, 32'h40, "soft reset status");
    wr(8'h08, 8'h01);
    check(outs, eo(1, 0, 4'h0, 4'h0), "write in soft reset");
    wr(8'h18, 8'h00);
    check(outs, eo(0, 0, 4'h0, 4'h0), "after release");
    rd(8'h20, 32'h0, "channel cleared");
    complete_run();
  end
endmodule
